// ---- verilog/recovery_map.svh ----
// register offsets, reset values and timing figures of the fault recovery unit
`ifndef RECOVERY_MAP_SVH
`define RECOVERY_MAP_SVH

`define RCV_CTRL_OFS 6'h00
`define RCV_FAULT_SEL_OFS 6'h04
`define RCV_INIT_DELAY_OFS 6'h08
`define RCV_REPEAT_DELAY_OFS 6'h0c
`define RCV_MAX_RESTARTS_OFS 6'h10
`define RCV_STATUS_OFS 6'h14
`define RCV_TIME_LEFT_OFS 6'h18
`define RCV_IRQ_STAT_OFS 6'h1c
`define RCV_IRQ_MASK_OFS 6'h20

`define RCV_CTRL_EN_BIT 0
`define RCV_CTRL_MODE_LSB 1
`define RCV_CTRL_MODE_MSB 2
`define RCV_ST_ACTIVE_BIT 0
`define RCV_ST_PENDING_BIT 1
`define RCV_ST_SELF_DIS_BIT 2
`define RCV_ST_ATT_LSB 8
`define RCV_ST_ATT_MSB 12

`define RCV_INIT_DELAY_RST 22'h00ea60
`define RCV_REPEAT_DELAY_RST 22'h01d4c0
`define RCV_MAX_RESTARTS_RST 5'h05
`define RCV_MAX_RESTARTS_LIM 5'h14
`define RCV_RUN_WORD 4'hf

`define RCV_CLK_PERIOD_NS 50
`define RCV_TICK_NS 1000000
`define RCV_TICK_CYCLES (`RCV_TICK_NS / `RCV_CLK_PERIOD_NS)
`define RCV_FLASH_MS 9'h0fa

`endif

// ---- verilog/recovery_pkg.sv ----
// types shared by the fault recovery unit and its bench
package recovery_pkg;

    typedef enum logic [1:0] {
        MODE_CLEAR,
        MODE_RESTART,
        MODE_START,
        MODE_SPARE
    } recovery_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DELAY,
        ST_FIRE,
        ST_SELF_DIS
    } recovery_state_t;

    typedef struct packed {
        logic trip_event;
        logic [4:0] trip_code;
        logic sources_active;
        logic motor_running;
        logic run_cmd;
        logic [3:0] ctrl_word;
        logic ext_trip_reset;
    } drive_in_t;

    typedef struct packed {
        logic fault_clear;
        logic restart;
    } drive_cmd_t;

endpackage : recovery_pkg

// ---- verilog/fault_recovery_unit.sv ----
// fault auto recovery sequencer with avalon-mm registers and interrupt
// Notes on behaviour
// - restart mode delays only after sources clear
// - delay expiry clears trip; restart requested only if run still held (restart) or control word runs (start)
// - no restart if stopped or run dropped
// - without restart, act as clear-only
// - restart mode flags pending restart
// - each restart attempt decrements attempts left
// - zero attempts plus selected trip self-disables in restart or start mode
// - start mode starts when control word runs
// - start mode flags each pending start
// - self-disabled until external trip reset or enable false
// - enable false then true re-arms
// - selected trip raises active flag
// - pending restart flashes run key led
// - flags and run key led clear on completion or disable
// - only selected trips activate the unit
// - enable false disables at once
// - clear-only mode clears trip without delay
`include "recovery_map.svh"

module fault_recovery_unit import recovery_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `RCV_TICK_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // drive sequencing side
    input drive_in_t drive_in,
    output drive_cmd_t drive_cmd,
    // indicators
    output logic recovery_active_flag,
    output logic restart_pending_flag,
    output logic keypad_panel_run_led,
    output logic irq
);

    function automatic logic fault_selected(input logic [31:0] sel, input logic [4:0] code);
        fault_selected = sel[code];
    endfunction : fault_selected

    function automatic logic mode_restarts(input recovery_mode_t m);
        mode_restarts = (m == MODE_RESTART) || (m == MODE_START);
    endfunction : mode_restarts

    logic recovery_enable_r;
    recovery_mode_t recovery_mode_select_r;
    logic [31:0] recovery_fault_select_r;
    logic [21:0] init_delay_r;
    logic [21:0] repeat_delay_r;
    logic [4:0] max_restarts_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_stat_nxt;
    recovery_state_t state_r;
    logic [4:0] attempts_r;
    logic [21:0] remain_r;
    logic restart_ok_r;
    logic retry_r;
    logic [31:0] tick_cnt_r;
    logic tick;
    logic [8:0] blink_cnt_r;
    logic blink_r;
    logic trip_hit;
    logic self_dis_go;
    logic will_restart, skip_delay;
    logic wr_go;
    logic rd_go;

    assign wr_go = avs_write && !avs_waitrequest;
    assign rd_go = avs_read && !avs_waitrequest;
    assign tick = (tick_cnt_r == TICK_CYCLES - 32'd1);
    assign trip_hit = drive_in.trip_event
        && fault_selected(recovery_fault_select_r, drive_in.trip_code);
    assign self_dis_go = trip_hit && (attempts_r == 5'h00)
        && mode_restarts(recovery_mode_select_r);
    always_comb begin
        if (recovery_mode_select_r == MODE_RESTART) begin
            will_restart = restart_ok_r && drive_in.run_cmd;
        end else if (recovery_mode_select_r == MODE_START) begin
            will_restart = (drive_in.ctrl_word == `RCV_RUN_WORD);
        end else begin
            will_restart = 1'b0;
        end
    end
    assign skip_delay = (recovery_mode_select_r == MODE_RESTART) && !will_restart;

    function automatic logic [31:0] read_mux(input logic [5:0] a);
        read_mux = 32'h0000_0000;
        if (a == `RCV_CTRL_OFS) begin
            read_mux[`RCV_CTRL_EN_BIT] = recovery_enable_r;
            read_mux[`RCV_CTRL_MODE_MSB:`RCV_CTRL_MODE_LSB] = recovery_mode_select_r;
        end else if (a == `RCV_FAULT_SEL_OFS) begin
            read_mux = recovery_fault_select_r;
        end else if (a == `RCV_INIT_DELAY_OFS) begin
            read_mux[21:0] = init_delay_r;
        end else if (a == `RCV_REPEAT_DELAY_OFS) begin
            read_mux[21:0] = repeat_delay_r;
        end else if (a == `RCV_MAX_RESTARTS_OFS) begin
            read_mux[4:0] = max_restarts_r;
        end else if (a == `RCV_STATUS_OFS) begin
            read_mux[`RCV_ST_ACTIVE_BIT] = recovery_active_flag;
            read_mux[`RCV_ST_PENDING_BIT] = restart_pending_flag;
            read_mux[`RCV_ST_SELF_DIS_BIT] = (state_r == ST_SELF_DIS);
            read_mux[`RCV_ST_ATT_MSB:`RCV_ST_ATT_LSB] = attempts_r;
        end else if (a == `RCV_TIME_LEFT_OFS) begin
            read_mux[21:0] = remain_r;
        end else if (a == `RCV_IRQ_STAT_OFS) begin
            read_mux[2:0] = irq_stat_r;
        end else if (a == `RCV_IRQ_MASK_OFS) begin
            read_mux[2:0] = irq_mask_r;
        end
    endfunction : read_mux

    // bus handshake: one wait cycle, then the access completes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? read_mux(avs_address) : 32'h0000_0000;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            recovery_enable_r <= 1'b0;
            recovery_mode_select_r <= MODE_CLEAR;
            recovery_fault_select_r <= 32'h0000_0000;
            init_delay_r <= `RCV_INIT_DELAY_RST;
            repeat_delay_r <= `RCV_REPEAT_DELAY_RST;
            max_restarts_r <= `RCV_MAX_RESTARTS_RST;
            irq_mask_r <= 3'h0;
        end else if (clk_en && wr_go) begin
            if (avs_address == `RCV_CTRL_OFS) begin
                recovery_enable_r <= avs_writedata[`RCV_CTRL_EN_BIT];
                recovery_mode_select_r <=
                    recovery_mode_t'(avs_writedata[`RCV_CTRL_MODE_MSB:`RCV_CTRL_MODE_LSB]);
            end else if (avs_address == `RCV_FAULT_SEL_OFS) begin
                recovery_fault_select_r <= avs_writedata;
            end else if (avs_address == `RCV_INIT_DELAY_OFS) begin
                init_delay_r <= avs_writedata[21:0];
            end else if (avs_address == `RCV_REPEAT_DELAY_OFS) begin
                repeat_delay_r <= avs_writedata[21:0];
            end else if (avs_address == `RCV_MAX_RESTARTS_OFS) begin
                max_restarts_r <= (avs_writedata[4:0] > `RCV_MAX_RESTARTS_LIM) ?
                    `RCV_MAX_RESTARTS_LIM : avs_writedata[4:0];
            end else if (avs_address == `RCV_IRQ_MASK_OFS) begin
                irq_mask_r <= avs_writedata[2:0];
            end
        end
    end

    // millisecond tick for delays and led flashing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_cnt_r <= 32'h0000_0000;
        end else if (clk_en) begin
            tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        end
    end

    // recovery sequence
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            attempts_r <= `RCV_MAX_RESTARTS_RST;
            remain_r <= 22'h000000;
            restart_ok_r <= 1'b0;
            retry_r <= 1'b0;
            recovery_active_flag <= 1'b0;
            drive_cmd <= '0;
        end else if (clk_en) begin
            drive_cmd <= '0;
            if (!recovery_enable_r) begin
                state_r <= ST_IDLE;
                recovery_active_flag <= 1'b0;
                attempts_r <= max_restarts_r;
                retry_r <= 1'b0;
                remain_r <= 22'h000000;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (self_dis_go) begin
                            state_r <= ST_SELF_DIS;
                        end else if (trip_hit) begin
                            state_r <= ST_WAIT;
                            recovery_active_flag <= 1'b1;
                            restart_ok_r <= drive_in.motor_running && drive_in.run_cmd;
                        end
                    end
                    ST_WAIT: begin
                        if (!drive_in.run_cmd) begin
                            restart_ok_r <= 1'b0;
                        end
                        if (!drive_in.sources_active) begin
                            if (!mode_restarts(recovery_mode_select_r) || skip_delay) begin
                                state_r <= ST_FIRE;
                            end else begin
                                remain_r <= retry_r ? repeat_delay_r : init_delay_r;
                                state_r <= ST_DELAY;
                            end
                        end
                    end
                    ST_DELAY: begin
                        if (!drive_in.run_cmd) begin
                            restart_ok_r <= 1'b0;
                        end
                        if ((remain_r == 22'h000000) || skip_delay) begin
                            state_r <= ST_FIRE;
                        end else if (tick) begin
                            remain_r <= remain_r - 22'h000001;
                        end
                    end
                    ST_FIRE: begin
                        drive_cmd.fault_clear <= 1'b1;
                        drive_cmd.restart <= will_restart;
                        if (will_restart) begin
                            attempts_r <= attempts_r - 5'h01;
                            retry_r <= 1'b1;
                        end
                        recovery_active_flag <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                    ST_SELF_DIS: begin
                        if (drive_in.ext_trip_reset) begin
                            state_r <= ST_IDLE;
                            attempts_r <= max_restarts_r;
                            retry_r <= 1'b0;
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // pending flag and flashing run key
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            restart_pending_flag <= 1'b0;
            keypad_panel_run_led <= 1'b0;
            blink_cnt_r <= 9'h000;
            blink_r <= 1'b0;
        end else if (clk_en) begin
            restart_pending_flag <= recovery_enable_r && will_restart
                && ((state_r == ST_WAIT) || (state_r == ST_DELAY));
            if (tick) begin
                blink_cnt_r <= (blink_cnt_r == `RCV_FLASH_MS - 9'h001) ?
                    9'h000 : blink_cnt_r + 9'h001;
                if (blink_cnt_r == `RCV_FLASH_MS - 9'h001) begin
                    blink_r <= !blink_r;
                end
            end
            keypad_panel_run_led <= restart_pending_flag && blink_r;
        end
    end

    // sticky events: activation, completion, self-disable; read clears, set wins
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (rd_go && (avs_address == `RCV_IRQ_STAT_OFS)) begin
            irq_stat_nxt = 3'h0;
        end
        if (recovery_enable_r && (state_r == ST_IDLE)) begin
            irq_stat_nxt[0] = irq_stat_nxt[0] || (trip_hit && !self_dis_go);
            irq_stat_nxt[2] = irq_stat_nxt[2] || self_dis_go;
        end
        if (recovery_enable_r && (state_r == ST_FIRE)) begin
            irq_stat_nxt[1] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_r <= 3'h0;
            irq <= 1'b0;
        end else if (clk_en) begin
            irq_stat_r <= irq_stat_nxt;
            irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_idle_go;
        clk_en && recovery_enable_r && (state_r == ST_IDLE);
    endsequence
    sequence s_fire_go;
        clk_en && recovery_enable_r && (state_r == ST_FIRE);
    endsequence
    sequence s_clear_out;
        drive_cmd.fault_clear && !drive_cmd.restart;
    endsequence

    unselected_idle_a: assert property (s_idle_go and (drive_in.trip_event && !trip_hit)
        |=> state_r == ST_IDLE) else $error("unselected trip left idle");
    disable_now_a: assert property (clk_en && !recovery_enable_r
        |=> state_r == ST_IDLE && !recovery_active_flag) else $error("disable not immediate");
    wait_sources_a: assert property (clk_en && state_r == ST_WAIT && drive_in.sources_active
        |=> state_r != ST_DELAY) else $error("delay started with active trip");
    restart_cmd_a: assert property (s_fire_go and will_restart
        |=> drive_cmd.fault_clear && drive_cmd.restart) else $error("restart not requested");
    stopped_norestart_a: assert property (s_fire_go and (recovery_mode_select_r == MODE_RESTART)
        and !restart_ok_r |=> s_clear_out) else $error("restart after run loss");
    attempt_count_a: assert property (drive_cmd.restart
        |-> attempts_r == 5'($past(attempts_r) - 5'h01)) else $error("attempts not decremented");
    self_disable_a: assert property (s_idle_go and self_dis_go
        |=> state_r == ST_SELF_DIS && !recovery_active_flag) else $error("no self disable");
    stay_disabled_a: assert property (clk_en && recovery_enable_r && state_r == ST_SELF_DIS
        && !drive_in.ext_trip_reset |=> state_r == ST_SELF_DIS) else $error("left self disable");
    clear_quick_a: assert property (clk_en && recovery_enable_r && state_r == ST_WAIT
        && !mode_restarts(recovery_mode_select_r) && !drive_in.sources_active ##1 s_fire_go
        |=> s_clear_out) else $error("clear-only mode slow or restarted");
    active_set_a: assert property (s_idle_go and trip_hit and !self_dis_go
        |=> recovery_active_flag && state_r == ST_WAIT) else $error("active flag missing");
    led_flash_a: assert property (keypad_panel_run_led |-> $past(restart_pending_flag))
        else $error("led lit without pending");

endmodule : fault_recovery_unit

// ---- tb/drive_seq_model.sv ----
// far-side model: trip sources, motor state and sequencing command word
module drive_seq_model import recovery_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // bench requests
    input wire logic trip_req,
    input wire logic [4:0] code_req,
    input wire logic [15:0] src_req,
    input wire logic start_req,
    input wire logic run_cmd_req,
    input wire logic [3:0] ctrl_req,
    input wire logic ext_reset_req,
    // unit side
    input wire drive_cmd_t drive_cmd,
    output drive_in_t drive_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] src_cnt_r;

    // sources stay active for the requested count after each trip
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_cnt_r <= 16'h0000;
            drive_in <= '0;
        end else begin
            drive_in.trip_event <= trip_req;
            // code only meaningful with the event, so it churns in between
            drive_in.trip_code <= trip_req ? code_req : ~drive_in.trip_code;
            if (trip_req) begin
                src_cnt_r <= src_req;
            end else if (src_cnt_r != 16'h0000) begin
                src_cnt_r <= src_cnt_r - 16'h0001;
            end
            drive_in.sources_active <= trip_req | (src_cnt_r != 16'h0000);
            // motor stops on a trip, runs after a start or a restart
            if (drive_in.trip_event) begin
                drive_in.motor_running <= 1'b0;
            end else if (start_req | drive_cmd.restart) begin
                drive_in.motor_running <= 1'b1;
            end
            drive_in.run_cmd <= run_cmd_req;
            drive_in.ctrl_word <= ctrl_req;
            drive_in.ext_trip_reset <= ext_reset_req;
        end
    end
endmodule : drive_seq_model

// ---- tb/fault_recovery_unit_tb.sv ----
// self-checking bench of the fault recovery unit
`include "recovery_map.svh"
module fault_recovery_unit_tb import recovery_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 4;
    localparam logic [31:0] SM = 32'h00001f07;
    logic ref_clk, rst, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    drive_in_t drive_in;
    drive_cmd_t drive_cmd;
    logic recovery_active_flag, restart_pending_flag, keypad_panel_run_led, irq;
    logic trip_req, start_req, run_cmd_req, ext_reset_req, last_rst, src_prev, led_seen;
    logic [4:0] code_req, c;
    logic [31:0] q1, q2;
    logic [15:0] src_req;
    logic [3:0] ctrl_req;
    int error_cnt = 0, checked = 0, seed, cyc = 0, clr_cnt = 0, fire_cyc = 0, src_fall_cyc = 0;
    int d, c0;

    fault_recovery_unit #(.TICK_CYCLES(TICK)) i_dut (.ref_clk(ref_clk), .rst(rst),
        .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .drive_in(drive_in), .drive_cmd(drive_cmd),
        .recovery_active_flag(recovery_active_flag), .restart_pending_flag(restart_pending_flag),
        .keypad_panel_run_led(keypad_panel_run_led), .irq(irq));
    drive_seq_model i_far (.ref_clk(ref_clk), .rst(rst), .trip_req(trip_req),
        .code_req(code_req), .src_req(src_req), .start_req(start_req),
        .run_cmd_req(run_cmd_req), .ctrl_req(ctrl_req), .ext_reset_req(ext_reset_req),
        .drive_cmd(drive_cmd), .drive_in(drive_in));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // pulse bookkeeping for latency figures
    always @(posedge ref_clk) begin
        cyc++;
        if (drive_cmd.fault_clear === 1'b1) begin
            clr_cnt++;
            last_rst = drive_cmd.restart;
            fire_cyc = cyc;
        end
        if (src_prev === 1'b1 && drive_in.sources_active === 1'b0) src_fall_cyc = cyc;
        src_prev = drive_in.sources_active;
        if (keypad_panel_run_led === 1'b1) led_seen = 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // delay window: programmed ms, plus free tick phase and pipeline
    function automatic logic [31:0] dly_ok(input int dd, input int ms);
        return 32'(dd >= ms * TICK && dd <= ms * TICK + TICK + 4);
    endfunction : dly_ok

    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check(32'(n < 50), 32'h1);
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [31:0] wd);
        logic [31:0] q;
        xfer(1'b1, a, wd, q);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        check(q & m, e);
    endtask : rd_chk

    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : look

    task automatic trip(input logic [4:0] code, input int s);
        @(posedge ref_clk);
        trip_req <= 1'b1;
        code_req <= code;
        src_req <= 16'(s);
        @(posedge ref_clk);
        trip_req <= 1'b0;
    endtask : trip

    task automatic pulse_req(input logic ext);
        @(posedge ref_clk);
        if (ext) ext_reset_req <= 1'b1;
        else start_req <= 1'b1;
        @(posedge ref_clk);
        ext_reset_req <= 1'b0;
        start_req <= 1'b0;
    endtask : pulse_req

    task automatic wait_fire(output int dd);
        int k, n;
        k = clr_cnt;
        n = 0;
        while (clr_cnt == k && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(n < 3000), 32'h1);
        dd = fire_cyc - src_fall_cyc;
    endtask : wait_fire

    initial begin
        repeat (30000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        seed = 54464;
        {rst, clk_en} = 2'b11;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {trip_req, start_req, run_cmd_req, ext_reset_req, code_req, src_req, ctrl_req} = '0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(`RCV_CTRL_OFS, '1, 32'h0);
        rd_chk(`RCV_INIT_DELAY_OFS, '1, 32'h0000ea60);
        rd_chk(`RCV_REPEAT_DELAY_OFS, '1, 32'h0001d4c0);
        rd_chk(`RCV_MAX_RESTARTS_OFS, '1, 32'h5);
        rd_chk(`RCV_STATUS_OFS, '1, 32'h500);
        rd_chk(6'h3c, '1, 32'h0);
        wr(`RCV_FAULT_SEL_OFS, 32'h108);
        wr(`RCV_INIT_DELAY_OFS, 32'h3);
        wr(`RCV_REPEAT_DELAY_OFS, 32'h6);
        wr(`RCV_MAX_RESTARTS_OFS, 32'h2);
        wr(`RCV_IRQ_MASK_OFS, 32'h1);
        wr(`RCV_CTRL_OFS, 32'h3);
        for (int i = 0; i < 3; i++) begin
            c = 5'($random(seed));
            if (c == 5'h03 || c == 5'h08) c = 5'h00;
            trip(c, 4);
            look(4);
            check(32'(recovery_active_flag), 32'h0);
        end
        run_cmd_req <= 1'b1;
        pulse_req(1'b0);
        trip(5'h03, 40);
        look(2);
        check(32'(recovery_active_flag), 32'h1);
        check(32'(restart_pending_flag), 32'h1);
        check(32'(irq), 32'h1);
        rd_chk(`RCV_IRQ_STAT_OFS, 32'h7, 32'h1);
        look(2);
        check(32'(irq), 32'h0);
        wait_fire(d);
        check(dly_ok(d, 3), 32'h1);
        check(32'(last_rst), 32'h1);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h100);
        trip(5'h08, 3 + ($random(seed) & 7));
        wait_fire(d);
        check(dly_ok(d, 6), 32'h1);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h0);
        trip(5'h03, 4);
        look(6);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h4);
        c0 = clr_cnt;
        look(60);
        check(32'(clr_cnt - c0), 32'h0);
        pulse_req(1'b1);
        look(3);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h200);
        pulse_req(1'b0);
        trip(5'h03, 4);
        run_cmd_req <= 1'b0;
        @(posedge ref_clk);
        run_cmd_req <= 1'b1;
        wait_fire(d);
        check(32'(last_rst), 32'h0);
        check(dly_ok(d, 0), 32'h1);
        trip(5'h08, 4);
        look(3);
        check(32'(restart_pending_flag), 32'h0);
        wait_fire(d);
        check(32'(last_rst), 32'h0);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h200);
        wr(`RCV_CTRL_OFS, 32'h5);
        ctrl_req <= 4'hf;
        trip(5'h03, 4);
        look(3);
        check(32'(restart_pending_flag), 32'h1);
        wait_fire(d);
        check(32'(last_rst), 32'h1);
        ctrl_req <= 4'h7;
        trip(5'h08, 4);
        wait_fire(d);
        check(32'(last_rst), 32'h0);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h100);
        for (int i = 0; i < 2; i++) begin
            wr(`RCV_CTRL_OFS, (i == 0) ? 32'h1 : 32'h7);
            trip(5'h08, 2 + ($random(seed) & 7));
            look(1);
            check(32'(recovery_active_flag), 32'h1);
            wait_fire(d);
            check(dly_ok(d, 0), 32'h1);
            check(32'(last_rst), 32'h0);
        end
        rd_chk(`RCV_IRQ_STAT_OFS, 32'h7, 32'h7);
        rd_chk(`RCV_IRQ_STAT_OFS, 32'h7, 32'h0);
        wr(`RCV_CTRL_OFS, 32'h3);
        pulse_req(1'b0);
        trip(5'h03, 4);
        wait_fire(d);
        check(32'(last_rst), 32'h1);
        trip(5'h03, 4);
        look(4);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h4);
        wr(`RCV_CTRL_OFS, 32'h0);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h200);
        wr(`RCV_INIT_DELAY_OFS, 32'd400);
        wr(`RCV_CTRL_OFS, 32'h3);
        rd_chk(`RCV_STATUS_OFS, SM, 32'h200);
        pulse_req(1'b0);
        led_seen = 1'b0;
        trip(5'h03, 4);
        look(1200);
        check(32'(led_seen), 32'h1);
        // frozen clock enable must stop the delay countdown
        xfer(1'b0, `RCV_TIME_LEFT_OFS, 32'h0, q1);
        clk_en <= 1'b0;
        repeat (40) @(posedge ref_clk);
        clk_en <= 1'b1;
        xfer(1'b0, `RCV_TIME_LEFT_OFS, 32'h0, q2);
        check(32'((q1 - q2) <= 32'h1), 32'h1);
        wr(`RCV_CTRL_OFS, 32'h0);
        look(2);
        check(32'(recovery_active_flag), 32'h0);
        check(32'({restart_pending_flag, keypad_panel_run_led}), 32'h0);
        c0 = clr_cnt;
        look(1700);
        check(32'(clr_cnt - c0), 32'h0);
        print_verdict();
    end
endmodule : fault_recovery_unit_tb
